/* File: verilog/fir_semi_par.sv */
// Purpose: Three-element semi-parallel FIR filter, 300 taps, one result
//          per 100 core cycles, with symmetric output rounding.
// Assumes: Source offers at most one sample per period on average.
// Notes:   TRANSPOSED selects the broadcast-data transposed structure.
//
// Notes on behaviour
// - three elements, 100 coefficients each
// - one result every 100 core cycles
// - samples and coefficients are 18 bits
// - each store holds coefficients and history
// - history is cyclic buffer in first half
// - store write enable is inverted clock enable
// - control scaled to three elements only
// - counter address, one more delay per element
// - comparator enable, one more delay per element
// - accumulator reloads via operand select, capture
// - output keeps most significant bits
// - rounding symmetric about zero
// - add 0.0111 plus carry when positive
// - round only the completed sum, later stage
// - rounder in general logic at result rate
// - transposed: one buffer broadcast to all
// - transposed: local accumulate, chain on last
// - transposed: results overlap across elements
// - transposed: latency about one bank length
`timescale 1ns/1ps
module fir_semi_par #(
    parameter int FIFO_DEPTH = fir_pkg::FIFO_DEPTH,
    parameter bit TRANSPOSED = 1'b0
) (
    input wire logic clk_i,                 // Core clock, 250 MHz
    input wire logic rst_i,                 // Async reset, active high
    input wire fir_pkg::sample_t sample_i,  // Input sample
    input wire logic sample_valid_i,        // Sample offered
    output logic sample_ready_o,            // Sample accepted
    input wire logic coef_wr_i,             // Coefficient write strobe
    input wire fir_pkg::bank_t coef_bank_i, // Element addressed
    input wire fir_pkg::tap_t coef_idx_i,   // Coefficient index in bank
    input wire fir_pkg::coef_t coef_i,      // Coefficient value
    output fir_pkg::out_t result_o,         // Rounded result
    output logic result_valid_o,            // Result strobe
    output logic underrun_o                 // Period had no sample
);
    import fir_pkg::*;

    // ****************************************
    // State
    // ****************************************
    // Tap 0 of a period reaches the chain end five edges after the enable
    localparam int LD_LEN = N_ELEM + 2;

    typedef struct packed {
        tap_t cnt;
        logic [N_ELEM-1:0][CNT_W-1:0] tapd;
        logic [N_ELEM-1:0] ced;
        logic [LD_LEN-1:0] ldp;
        acc_t [N_ELEM-1:0] casc;
        acc_t acc;
        acc_t [N_ELEM-1:0] tacc;
        acc_t [N_ELEM-1:0] tz;
        acc_t cap;
        logic cap_v;
        out_t res;
        logic res_v;
        logic unr;
    } top_state_t;

    top_state_t st;
    top_state_t next_st;

    logic ce_base;
    logic tap_load;
    logic [6:0] adder_operand_select;
    logic [N_ELEM-1:0] elem_ce;
    tap_t elem_tap [N_ELEM];
    prod_t prod [N_ELEM];
    sample_t rd [N_ELEM];
    sample_t evict [N_ELEM];
    sample_t fifo_data;
    logic fifo_valid;
    sample_t new_sample;

    // ****************************************
    // Symmetric rounding
    // ****************************************
    // Zero counts as positive; it stays zero either way
    function automatic out_t sym_round(input acc_t v);
        logic [ACC_W:0] s;
        logic [ACC_W:0] cin;
        cin = '0;
        cin[0] = ~v[ACC_W-1];
        s = {v[ACC_W-1], v} + RND_CONST + cin;
        // Only the largest positive sums can carry out; clamp them
        if (s[ACC_W] != s[ACC_W-1]) begin
            sym_round = {s[ACC_W], {(OUT_W - 1){~s[ACC_W]}}};
        end else begin
            sym_round = out_t'(s[ACC_W-1:FRAC_W]);
        end
    endfunction

    // ****************************************
    // Sample FIFO
    // ****************************************
    fir_fifo #(
        .W(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_data_i(sample_i),
        .in_valid_i(sample_valid_i),
        .in_ready_o(sample_ready_o),
        .out_data_o(fifo_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(ce_base)
    );

    // One sample leaves per period; an empty FIFO feeds a zero
    assign new_sample = fifo_valid ? fifo_data : '0;

    // ****************************************
    // Element control fan-out
    // ****************************************
    // Comparator on the period counter
    assign ce_base = (st.cnt == CNT_LAST);

    always_comb begin
        for (int k = 0; k < N_ELEM; k++) begin
            if (TRANSPOSED || k == 0) begin
                elem_ce[k] = ce_base;
                elem_tap[k] = st.cnt;
            end else begin
                elem_ce[k] = st.ced[k];
                elem_tap[k] = st.tapd[k];
            end
        end
    end

    // ****************************************
    // Multiply-add elements
    // ****************************************
    for (genvar k = 0; k < N_ELEM; k++) begin : g_elem
        localparam bit BUF = (k == 0) || !TRANSPOSED;
        localparam int HIST = (TRANSPOSED && k == 0) ? N_ELEM * TAPS : TAPS;
        localparam int STRIDE = TRANSPOSED ? N_ELEM : 1;
        elem_ctl_if ec ();
        sample_t din;
        sample_t mul;

        // Only the buffering elements ever write history
        assign ec.ce_n = BUF ? ~elem_ce[k] : 1'b1;
        assign ec.tap = elem_tap[k];
        assign ec.coef_wr = coef_wr_i && (coef_bank_i == BANK_W'(k));
        assign ec.coef_idx = coef_idx_i;
        assign ec.coef_val = coef_i;

        if (k == 0 || TRANSPOSED) begin : g_first
            assign din = new_sample;
        end else begin : g_chain
            // History hands its oldest sample to the next bank
            assign din = evict[k-1];
        end
        // Broadcast costs fan-out timing, traded for one buffer
        assign mul = TRANSPOSED ? rd[0] : rd[k];

        fir_mac_elem #(
            .HIST(HIST),
            .STRIDE(STRIDE)
        ) u_elem (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ctl(ec),
            .din_i(din),
            .mul_i(mul),
            .rd_o(rd[k]),
            .evict_o(evict[k]),
            .prod_o(prod[k])
        );
    end

    // ****************************************
    // Sequencing and accumulation
    // ****************************************
    assign tap_load = st.ldp[LD_LEN-1];
    // Single-bit change between accumulate and reload
    assign adder_operand_select = tap_load ? OPSEL_LOAD : OPSEL_ACC;

    always_comb begin
        acc_t chain;
        chain = '0;
        next_st = st;

        // Period counter 0..99
        next_st.cnt = ce_base ? '0 : st.cnt + 1'b1;
        // One more register per element down the chain
        next_st.tapd[0] = '0;
        next_st.ced[0] = 1'b0;
        for (int k = 1; k < N_ELEM; k++) begin
            next_st.tapd[k] = (k == 1) ? st.cnt : st.tapd[k-1];
            next_st.ced[k] = (k == 1) ? ce_base : st.ced[k-1];
        end
        next_st.ldp = {st.ldp[LD_LEN-2:0], ce_base};
        next_st.unr = ce_base && !fifo_valid;
        next_st.cap_v = 1'b0;

        if (!TRANSPOSED) begin
            // Adder chain, each stage one cycle after the last
            next_st.casc[0] = acc_t'(prod[0]);
            for (int k = 1; k < N_ELEM; k++) begin
                next_st.casc[k] = st.casc[k-1] + acc_t'(prod[k]);
            end
            if (adder_operand_select[1]) begin
                next_st.acc = st.acc + st.casc[N_ELEM-1];
            end else begin
                next_st.acc = st.casc[N_ELEM-1];
            end
            if (tap_load) begin
                next_st.cap = st.acc;
                next_st.cap_v = 1'b1;
            end
        end else begin
            // Each element sums its bank locally over the period
            for (int k = 0; k < N_ELEM; k++) begin
                if (st.ldp[0]) begin
                    next_st.tacc[k] = acc_t'(prod[k]);
                end else begin
                    next_st.tacc[k] = st.tacc[k] + acc_t'(prod[k]);
                end
            end
            // Last product of the period: pass sums down the chain
            if (ce_base) begin
                for (int k = 0; k < N_ELEM; k++) begin
                    chain = st.tacc[k] + acc_t'(prod[k]);
                    if (k > 0) begin
                        chain = chain + st.tz[k-1];
                    end
                    next_st.tz[k] = chain;
                end
                // Earlier elements already hold later results
                next_st.cap = chain;
                next_st.cap_v = 1'b1;
            end
        end

        // Rounder runs once per period on the finished sum
        if (st.cap_v) begin
            next_st.res = sym_round(st.cap);
        end
        next_st.res_v = st.cap_v;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign result_o = st.res;
    assign result_valid_o = st.res_v;
    assign underrun_o = st.unr;

endmodule

/* File: verilog/fir_pkg.sv */
// Purpose: Shared constants and types of the semi-parallel FIR filter.
// Assumes: One 250 MHz core clock; signed two's complement data.
// Notes:   Widths here shape every datapath in the filter.
package fir_pkg;

    // ****************************************
    // Structure
    // ****************************************
    localparam int N_ELEM = 3;
    localparam int TAPS = 100;
    localparam int DATA_W = 18;
    localparam int COEF_W = 18;
    localparam int OUT_W = 18;
    localparam int PROD_W = DATA_W + COEF_W;
    // Full sum of every product, no overflow possible
    localparam int ACC_W = PROD_W + $clog2(N_ELEM * TAPS);
    localparam int FRAC_W = ACC_W - OUT_W;
    localparam int CNT_W = 7;
    localparam int BANK_W = 2;
    localparam int FIFO_DEPTH = 8;

    // ****************************************
    // Control values
    // ****************************************
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TAPS - 1);
    localparam logic [6:0] OPSEL_ACC = 7'h12;
    localparam logic [6:0] OPSEL_LOAD = 7'h10;
    // 0.0111... aligned to the dropped fraction
    localparam logic [ACC_W:0] RND_CONST =
        {{(OUT_W + 2){1'b0}}, {(FRAC_W - 1){1'b1}}};

    // ****************************************
    // Types
    // ****************************************
    typedef logic signed [DATA_W-1:0] sample_t;
    typedef logic signed [COEF_W-1:0] coef_t;
    typedef logic signed [PROD_W-1:0] prod_t;
    typedef logic signed [ACC_W-1:0] acc_t;
    typedef logic signed [OUT_W-1:0] out_t;
    typedef logic [CNT_W-1:0] tap_t;
    typedef logic [BANK_W-1:0] bank_t;

endpackage

/* File: verilog/elem_ctl_if.sv */
// Purpose: Control bundle from the sequencer to one multiply-add element.
// Assumes: Single clock domain.
// Notes:   ce_n low marks the one write cycle of a result period.
`timescale 1ns/1ps
interface elem_ctl_if;
    import fir_pkg::*;
    logic ce_n;
    tap_t tap;
    logic coef_wr;
    tap_t coef_idx;
    coef_t coef_val;
    modport ctl (output ce_n, tap, coef_wr, coef_idx, coef_val);
    modport elem (input ce_n, tap, coef_wr, coef_idx, coef_val);
endinterface

/* File: verilog/fir_fifo.sv */
// Purpose: Sample FIFO between the source and the filter core.
// Assumes: Same clock on both sides.
// Notes:   Ready and valid are registered; ready rises one edge
//          after reset release.
`timescale 1ns/1ps
module fir_fifo #(
    parameter int W = 18,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,            // Core clock
    input wire logic rst_i,            // Async reset, active high
    input wire logic [W-1:0] in_data_i, // Word from source
    input wire logic in_valid_i,       // Source offers a word
    output logic in_ready_o,           // FIFO accepts a word
    output logic [W-1:0] out_data_o,   // Oldest word
    output logic out_valid_o,          // Oldest word present
    input wire logic out_ready_i       // Drain takes the word
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] rd;
        logic [PW-1:0] wr;
        logic [CW-1:0] cnt;
        logic in_rdy;
        logic out_vld;
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t next_st;
    logic push;
    logic pop;

    always_comb begin
        next_st = st;
        push = in_valid_i && st.in_rdy;
        pop = out_ready_i && st.out_vld;
        if (push) begin
            next_st.mem[st.wr] = in_data_i;
            next_st.wr = (st.wr == PW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = (st.rd == PW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
        end
        if (push && !pop) begin
            next_st.cnt = st.cnt + 1'b1;
        end else if (pop && !push) begin
            next_st.cnt = st.cnt - 1'b1;
        end
        next_st.in_rdy = (next_st.cnt != CW'(DEPTH));
        next_st.out_vld = (next_st.cnt != '0);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign in_ready_o = st.in_rdy;
    assign out_valid_o = st.out_vld;
    assign out_data_o = st.mem[st.rd];
endmodule

/* File: verilog/fir_mac_elem.sv */
// Purpose: One multiply-add element with its shared history/coefficient store.
// Assumes: Sequencer holds ce_n low for one cycle per result period.
// Notes:   Words 0..HIST-1 are the cyclic history, the rest coefficients.
`timescale 1ns/1ps
module fir_mac_elem #(
    parameter int HIST = 100,
    parameter int STRIDE = 1
) (
    input wire logic clk_i,            // Core clock
    input wire logic rst_i,            // Async reset, active high
    elem_ctl_if.elem ctl,              // Tap, enable, coefficient load
    input wire fir_pkg::sample_t din_i, // Sample for the history
    input wire fir_pkg::sample_t mul_i, // Data operand of the multiply
    output fir_pkg::sample_t rd_o,     // History word for current tap
    output fir_pkg::sample_t evict_o,  // Oldest sample pushed out
    output fir_pkg::prod_t prod_o      // Registered product
);
    import fir_pkg::*;
    localparam int WORDS = HIST + TAPS;
    localparam int AW = $clog2(WORDS);

    typedef struct packed {
        logic [WORDS-1:0][DATA_W-1:0] mem;
        logic [AW-1:0] wp;
        sample_t evict;
        prod_t prod;
    } elem_state_t;

    elem_state_t st;
    elem_state_t next_st;
    logic we;
    logic [AW-1:0] np;
    logic [AW-1:0] off;
    logic [AW-1:0] ridx;
    coef_t cf;
    prod_t p;

    always_comb begin
        next_st = st;
        we = ~ctl.ce_n;
        np = (st.wp == AW'(HIST - 1)) ? '0 : st.wp + 1'b1;
        off = AW'(ctl.tap * STRIDE);
        // Modular wrap is exact even if the sum overflows AW bits
        ridx = (st.wp >= off) ? st.wp - off : st.wp + AW'(HIST) - off;
        // Read-first: the last tap must see the word being replaced
        rd_o = sample_t'(st.mem[ridx]);
        if (we) begin
            next_st.evict = sample_t'(st.mem[np]);
            next_st.mem[np] = din_i;
            next_st.wp = np;
        end
        if (ctl.coef_wr) begin
            next_st.mem[AW'(HIST) + AW'(ctl.coef_idx)] = ctl.coef_val;
        end
        cf = coef_t'(st.mem[AW'(HIST) + AW'(ctl.tap)]);
        p = mul_i * cf;
        next_st.prod = p;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign evict_o = st.evict;
    assign prod_o = st.prod;
endmodule

/* File: testbench/fir_semi_par_sva.sv */
// Purpose: Port-level timing checks of the FIR filter.
// Assumes: One clock; one result strobe per 100 cycles.
// Notes: gap counts cycles since the last result strobe.
`timescale 1ns/1ps
module fir_semi_par_sva
    import fir_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk_i, // Core clock
    input wire logic rst_i, // Async reset
    input wire fir_pkg::sample_t sample_i, // Sample
    input wire logic sample_valid_i, // Sample offered
    input wire logic sample_ready_o, // Room in FIFO
    input wire logic coef_wr_i, // Coef strobe
    input wire fir_pkg::bank_t coef_bank_i, // Coef bank
    input wire fir_pkg::tap_t coef_idx_i, // Coef index
    input wire fir_pkg::coef_t coef_i, // Coef value
    input wire fir_pkg::out_t result_o, // Result
    input wire logic result_valid_o, // Result strobe
    input wire logic underrun_o // Empty period
);
    logic [7:0] gap;
    logic seen;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Saturates so a lost strobe cannot wrap into a match
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gap <= 8'h00;
            seen <= 1'b0;
        end else if (result_valid_o) begin
            gap <= 8'h00;
            seen <= 1'b1;
        end else if (gap != 8'hff) begin
            gap <= gap + 8'h01;
        end
    end

    property p_period;
        seen && result_valid_o |-> gap == 8'h63;
    endproperty
    a_period: assert property (p_period)
        else $error("result strobe not 100 cycles apart");

    property p_gap_max;
        seen |-> gap <= 8'h63;
    endproperty
    a_gap_max: assert property (p_gap_max)
        else $error("result strobe missing");

    property p_strobe;
        result_valid_o |=> !result_valid_o [*8];
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("result strobe longer than one cycle");

    property p_hold;
        !result_valid_o |-> $stable(result_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("result changed between strobes");

    property p_und_pulse;
        underrun_o |=> !underrun_o [*8];
    endproperty
    a_und_pulse: assert property (p_und_pulse)
        else $error("underrun longer than one cycle");

    property p_und_res;
        underrun_o |-> ##106 result_valid_o;
    endproperty
    a_und_res: assert property (p_und_res)
        else $error("result not 106 cycles after underrun");

    property p_und_phase;
        seen && underrun_o |-> gap == 8'h5d;
    endproperty
    a_und_phase: assert property (p_und_phase)
        else $error("underrun at wrong point of period");

    property p_ready_hold;
        sample_ready_o && !sample_valid_i |=> sample_ready_o;
    endproperty
    a_ready_hold: assert property (p_ready_hold)
        else $error("ready dropped without an accepted sample");
endmodule

/* File: testbench/fir_source_model.sv */
// Purpose: Upstream sample source for the FIR filter bench.
// Assumes: Called from the bench just after a rising edge.
// Notes: Holds the sample until ready is seen on an edge.
`timescale 1ns/1ps
module fir_source_model
    import fir_pkg::*;
(
    input wire logic clk_i, // Core clock
    input wire logic ready_i, // Filter has room
    output fir_pkg::sample_t sample_o, // Offered sample
    output logic valid_o // Sample offered
);
    initial begin
        sample_o = '0;
        valid_o = 1'b0;
    end

    // One sample per call, after gap + 1 idle cycles
    task automatic push(input sample_t v, input int gap);
        repeat (gap) @(posedge clk_i);
        @(posedge clk_i);
        #1;
        sample_o = v;
        valid_o = 1'b1;
        @(posedge clk_i);
        while (ready_i !== 1'b1)
            @(posedge clk_i);
        #1;
        valid_o = 1'b0;
        // Released line must not look like a held sample
        sample_o = ~v;
    endtask
endmodule

/* File: testbench/semi_parallel_fir_filter_tb_top.sv */
// Purpose: Self-checking bench of the semi-parallel FIR filter.
// Assumes: Sample after result strobe m is newest at strobe m+2.
// Notes: Reference sums all 300 taps from its own sample log.
`timescale 1ns/1ps
module semi_parallel_fir_filter_tb_top;
    import fir_pkg::*;
    logic clk_i, rst_i, coef_wr_i, sample_valid_i, sample_ready_o;
    logic result_valid_o, underrun_o;
    sample_t sample_i;
    bank_t coef_bank_i;
    tap_t coef_idx_i;
    coef_t coef_i;
    out_t result_o;
    int num_errors, check_count, pidx, cycles;
    longint xv[int];

    fir_semi_par i_fir_semi_par (.clk_i(clk_i), .rst_i(rst_i),
        .sample_i(sample_i), .sample_valid_i(sample_valid_i),
        .sample_ready_o(sample_ready_o), .coef_wr_i(coef_wr_i),
        .coef_bank_i(coef_bank_i), .coef_idx_i(coef_idx_i),
        .coef_i(coef_i), .result_o(result_o),
        .result_valid_o(result_valid_o), .underrun_o(underrun_o));
    fir_source_model i_fir_source_model (.clk_i(clk_i),
        .ready_i(sample_ready_o), .sample_o(sample_i),
        .valid_o(sample_valid_i));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 50000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input out_t got, input out_t exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask

    function automatic coef_t coef_of(input int k);
        case (k)
            0: return 18'h0_0400;
            99: return 18'h0_0BB8;
            100: return 18'h3_EC78;
            199: return 18'h0_0007;
            200: return 18'h1_FFFF;
            299: return 18'h2_0000;
            default: return 18'h0_0000;
        endcase
    endfunction

    // Half away from zero, then keep the top 18 bits
    function automatic out_t sym_round(input longint y);
        longint a;
        a = (y < 0) ? -y : y;
        a = (a + 64'h400_0000) >>> 27;
        return out_t'((y < 0) ? -a : a);
    endfunction

    task automatic wait_pulse(output bit und);
        int n;
        n = 0;
        und = 1'b0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
            if (underrun_o === 1'b1)
                und = 1'b1;
        end while (result_valid_o !== 1'b1 && n < 150);
        check(out_t'(result_valid_o), out_t'(1));
    endtask

    task automatic period(input bit send, input sample_t v, input int gap);
        bit und;
        longint acc;
        wait_pulse(und);
        pidx++;
        acc = 0;
        for (int k = 0; k < 300; k++)
            if (xv.exists(pidx - 2 - k))
                acc += longint'(coef_of(k)) * xv[pidx - 2 - k];
        check(result_o, sym_round(acc));
        if (pidx > 1)
            check(out_t'(und), out_t'(!xv.exists(pidx - 1)));
        if (send) begin
            xv[pidx] = longint'(v);
            i_fir_source_model.push(v, gap);
        end
    endtask

    task automatic t_reset();
        repeat (5) @(posedge clk_i);
        #1;
        check(result_o, '0);
        check(out_t'({result_valid_o, underrun_o, sample_ready_o}), '0);
        rst_i = 1'b0;
        @(posedge clk_i);
        #1;
        check(out_t'(sample_ready_o), out_t'(1));
        $display("test reset done");
    endtask

    task automatic t_coef_load();
        for (int k = 0; k < 300; k++) begin
            coef_wr_i = 1'b1;
            coef_bank_i = bank_t'(k / 100);
            coef_idx_i = tap_t'(k % 100);
            coef_i = coef_of(k);
            @(posedge clk_i);
            #1;
        end
        coef_wr_i = 1'b0;
        $display("test coef load done");
    endtask

    task automatic t_rounding();
        sample_t r[6];
        r = '{18'h1_0000, 18'h3_0000, 18'h0_FFFF, 18'h3_0001,
            18'h1_8000, 18'h0_0000};
        for (int i = 0; i < 6; i++)
            period(1'b1, r[i], i % 3);
        $display("test rounding done");
    endtask

    task automatic t_bank_span();
        period(1'b1, 18'h1_86A0, 0);
        for (int i = 0; i < 301; i++)
            period(1'b1, 18'h0_0000, 0);
        $display("test bank span done");
    endtask

    task automatic t_underrun();
        for (int i = 0; i < 4; i++)
            period(1'b0, 18'h0_0000, 0);
        $display("test underrun done");
    endtask

    task automatic t_fifo_fill();
        bit und;
        int n;
        wait_pulse(und);
        for (int i = 0; i < 8; i++)
            i_fir_source_model.push(sample_t'(i + 1), 0);
        check(out_t'(sample_ready_o), out_t'(0));
        i_fir_source_model.push(18'h0_0009, 0);
        n = 0;
        und = 1'b0;
        while (!und && n < 12) begin
            wait_pulse(und);
            n++;
        end
        check(out_t'(n), out_t'(10));
        $display("test fifo fill done");
    endtask

    initial begin
        rst_i = 1'b1;
        coef_wr_i = 1'b0;
        coef_bank_i = '0;
        coef_idx_i = '0;
        coef_i = '0;
        num_errors = 0;
        check_count = 0;
        pidx = 0;
        cycles = 0;
        t_reset();
        t_coef_load();
        t_rounding();
        t_bank_span();
        t_underrun();
        t_fifo_fill();
        complete_run();
    end
endmodule

bind fir_semi_par fir_semi_par_sva #(.FIFO_DEPTH(FIFO_DEPTH))
    i_fir_semi_par_sva (.clk_i(clk_i), .rst_i(rst_i),
    .sample_i(sample_i), .sample_valid_i(sample_valid_i),
    .sample_ready_o(sample_ready_o), .coef_wr_i(coef_wr_i),
    .coef_bank_i(coef_bank_i), .coef_idx_i(coef_idx_i),
    .coef_i(coef_i), .result_o(result_o),
    .result_valid_o(result_valid_o), .underrun_o(underrun_o));
